// *** rtl/mcif_defines.vh ***
// Purpose: Constants for the monitor CPU interface control register bank
// Assumes: 32-bit coprocessor data, coprocessor 15 encodings
// Notes:   Included by the bank and its access decoder
`ifndef MCIF_DEFINES_VH
`define MCIF_DEFINES_VH

`define MCIF_COPROC          4'hF
`define MCIF_OPC1            3'h6
`define MCIF_CRN             4'hC
`define MCIF_CRM             4'hC
`define MCIF_OPC2_CTRL       3'h4
`define MCIF_OPC2_SRE        3'h5
`define MCIF_OPC2_GRP1       3'h7

`define MCIF_CTRL_EOI_BIT    2
`define MCIF_CTRL_CBPNS_BIT  1
`define MCIF_CTRL_CBPS_BIT   0
`define MCIF_GRP1_S_BIT      1
`define MCIF_GRP1_NS_BIT     0
`define MCIF_SRE_EN_BIT      3
`define MCIF_SRE_DIB_BIT     2
`define MCIF_SRE_DFB_BIT     1
`define MCIF_SRE_SRE_BIT     0

`define MCIF_CTRL_RESET      3'h0
`define MCIF_GRP1_RESET      2'h0
`define MCIF_SRE_RESET       4'h0

`define MCIF_SEL_NONE        2'h0
`define MCIF_SEL_CTRL        2'h1
`define MCIF_SEL_GRP1        2'h2
`define MCIF_SEL_SRE         2'h3

`define MCIF_RESP_OK         2'h0
`define MCIF_RESP_UNDEF      2'h1
`define MCIF_RESP_TRAP_EL2   2'h2
`define MCIF_RESP_TRAP_EL3   2'h3

`endif

// *** rtl/mcif_decode.v ***
// Purpose: Decodes a coprocessor access into a monitor register select
// Assumes: Access fields are valid in the same cycle as the strobe
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "mcif_defines.vh"

module mcif_decode (
  input  wire [3:0] coproc,
  input  wire [2:0] opc1,
  input  wire [3:0] crn,
  input  wire [3:0] crm,
  input  wire [2:0] opc2,
  output reg  [1:0] sel
);

  wire space_hit;

  assign space_hit = (coproc == `MCIF_COPROC) && (opc1 == `MCIF_OPC1) &&
                     (crn == `MCIF_CRN) && (crm == `MCIF_CRM);

  always @* begin
    sel = `MCIF_SEL_NONE;
    if (space_hit) begin
      case (opc2)
        `MCIF_OPC2_CTRL: sel = `MCIF_SEL_CTRL;   // R6
        `MCIF_OPC2_GRP1: sel = `MCIF_SEL_GRP1;   // R7
        `MCIF_OPC2_SRE:  sel = `MCIF_SEL_SRE;    // R23
        default:         sel = `MCIF_SEL_NONE;
      endcase
    end
  end

endmodule // mcif_decode

// *** rtl/mcif_regs.v ***
// Purpose: Monitor control, Group 1 enable and system register enable bank
// Assumes: One access at a time; answer one cycle after the strobe
// Notes:   Bypass support and sysreg-only build are parameters
//
// Contract
// R1 - EOI split mode 0: EOI writes drop priority and deactivate together
// R2 - EOI split mode 1: EOI drops priority only; deactivate register deactivates
// R3 - Nonsecure shared point 0: point 0 for group 0, point 1 for nonsecure group 1
// R4 - Nonsecure shared point 1: nonsecure point 1 accesses reach point 0 state
// R5 - Secure shared point 1: secure EL1 or non-monitor EL3 point 1 reaches point 0
// R6 - Control register at cp15, opc1 6, CRn 12, CRm 12, opc2 4
// R7 - Group 1 enable register at same encoding with opc2 7
// R8 - Control and Group 1 enable reachable only in monitor mode
// R9 - Sysreg enable 0 makes EL3 accesses to these registers undefined
// R10 - Hyp trap bit with nonsecure EL1 access traps to EL2
// R11 - Bit 1 gates secure Group 1; banked secure enable aliases it
// R12 - Bit 0 gates nonsecure Group 1; banked nonsecure enable aliases it
// R13 - Enable falling with 1-of-N group 1 pending retargets it elsewhere
// R14 - Pending interrupt released when an enable clears
// R15 - Group 1 enable fields reset to 0
// R16 - Lower access enable 0 traps lower sysreg enable accesses to EL3
// R17 - Sysreg enable 0 makes lower access enable act as 1
// R18 - Bit 2 disables IRQ bypass; read one when unsupported
// R19 - Bit 1 disables FIQ bypass; read one when unsupported
// R20 - Sysreg enable 0 makes other interface sysreg accesses undefined
// R21 - Sysreg-only build reads sysreg enable as one, writes ignored
// R22 - Writable bypass and sysreg enable bits reset to 0
// R23 - Sysreg enable register at cp15, opc1 6, CRn 12, CRm 12, opc2 5
// R24 - Reserved bits read zero; writes to them ignored
`timescale 1ns/1ps
`include "mcif_defines.vh"

module mcif_regs #(
  parameter IRQ_BYPASS_SUPPORTED = 1,
  parameter FIQ_BYPASS_SUPPORTED = 1,
  parameter SYSREG_ONLY          = 0
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        ACC_VALID,
  input  wire        ACC_WRITE,
  input  wire [3:0]  ACC_COPROC,
  input  wire [2:0]  ACC_OPC1,
  input  wire [3:0]  ACC_CRN,
  input  wire [3:0]  ACC_CRM,
  input  wire [2:0]  ACC_OPC2,
  input  wire [31:0] ACC_WDATA,
  input  wire        MONITOR_MODE,
  input  wire        NONSECURE,
  input  wire [1:0]  EXC_LEVEL,
  input  wire        HYP_TRAP_CP15_C12,
  input  wire        BANK_G1_WRITE,
  input  wire        BANK_G1_SECURE,
  input  wire        BANK_G1_DATA,
  input  wire        LOWER_SRE_ACCESS,
  input  wire        OTHER_SYSREG_ACCESS,
  input  wire        EOI_WRITE,
  input  wire        EOI_AT_EL3,
  input  wire        DEACT_WRITE,
  input  wire        BPR1_ACCESS,
  input  wire        HPPI_VALID,
  input  wire        HPPI_GROUP1,
  input  wire        HPPI_SECURE,
  input  wire        HPPI_ONE_OF_N,
  output reg         ACC_DONE,
  output reg  [1:0]  ACC_RESP,
  output reg  [31:0] ACC_RDATA,
  output reg         EOI_SPLIT_MODE_MONITOR,
  output reg         SHARED_BINARY_POINT_NONSECURE,
  output reg         SHARED_BINARY_POINT_SECURE,
  output reg         SECURE_GROUP1_GATE,
  output reg         NONSECURE_GROUP1_GATE,
  output reg         IRQ_BYPASS_DISABLE,
  output reg         FIQ_BYPASS_DISABLE,
  output reg         SYSREG_INTERFACE_ENABLE,
  output reg         LOWER_SRE_TRAP_EL3,
  output reg         OTHER_SYSREG_UNDEF,
  output reg         PRIORITY_DROP,
  output reg         DEACTIVATE,
  output reg         BPR1_USES_BPR0,
  output reg         HPPI_RETARGET,
  output reg         HPPI_RELEASE
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg  [2:0] ctrl;
  reg  [1:0] grp1;
  reg        sre_en;
  reg        irq_bypass_disable;
  reg        dfb;
  reg        sysreg_interface_enable;
  wire [1:0] sel;

  reg  [1:0] next_resp;
  reg  [31:0] next_rdata;
  reg        do_write;
  reg  [1:0] next_grp1;
  reg        fall_s;
  reg        fall_ns;

  wire       sre_eff;
  wire       sre_en_eff;
  wire       dib_eff;
  wire       dfb_eff;

  mcif_decode u_decode (
    .coproc (ACC_COPROC),
    .opc1   (ACC_OPC1),
    .crn    (ACC_CRN),
    .crm    (ACC_CRM),
    .opc2   (ACC_OPC2),
    .sel    (sel)
  );

  // Unsupported features read as one and ignore writes
  assign sre_eff    = (SYSREG_ONLY != 0) ? 1'b1 : sysreg_interface_enable;                       // R21
  assign sre_en_eff = ((SYSREG_ONLY != 0) || !sre_eff) ? 1'b1 : sre_en;      // R17
  assign dib_eff    = (IRQ_BYPASS_SUPPORTED == 0) ? 1'b1 : irq_bypass_disable;              // R18
  assign dfb_eff    = (FIQ_BYPASS_SUPPORTED == 0) ? 1'b1 : dfb;              // R19

  ////////////////////////////////////////////////////////////////////////////
  // Access checks and read data

  function [1:0] mcif_check;
    input [1:0] s;
    input       mon;
    input       ns;
    input [1:0] el;
    input       t12;
    input       sre_on;
    begin
      mcif_check = `MCIF_RESP_OK;
      if (s == `MCIF_SEL_NONE)
        mcif_check = `MCIF_RESP_UNDEF;
      else if (ns && (el == 2'h1) && t12)
        mcif_check = `MCIF_RESP_TRAP_EL2;                                    // R10
      else if (!mon)
        mcif_check = `MCIF_RESP_UNDEF;                                       // R8
      else if ((s != `MCIF_SEL_SRE) && !sre_on)
        mcif_check = `MCIF_RESP_UNDEF;                                       // R9
    end
  endfunction

  always @* begin
    next_resp  = mcif_check(sel, MONITOR_MODE, NONSECURE, EXC_LEVEL, HYP_TRAP_CP15_C12, sre_eff);
    next_rdata = 32'h0;                                                      // R24
    do_write   = ACC_VALID && ACC_WRITE && (next_resp == `MCIF_RESP_OK);
    case (sel)
      `MCIF_SEL_CTRL: next_rdata[2:0] = ctrl;
      `MCIF_SEL_GRP1: next_rdata[1:0] = grp1;
      `MCIF_SEL_SRE:  next_rdata[3:0] = {sre_en_eff && (SYSREG_ONLY != 0) ? 1'b1 : sre_en,
                                         dib_eff, dfb_eff, sre_eff};
      default:        next_rdata = 32'h0;
    endcase
    if (next_resp != `MCIF_RESP_OK)
      next_rdata = 32'h0;
  end

  // Banked enables alias the monitor bits; the monitor write wins a collision
  always @* begin
    next_grp1 = grp1;
    if (BANK_G1_WRITE) begin
      if (BANK_G1_SECURE)
        next_grp1[`MCIF_GRP1_S_BIT] = BANK_G1_DATA;                          // R11
      else
        next_grp1[`MCIF_GRP1_NS_BIT] = BANK_G1_DATA;                         // R12
    end
    if (do_write && (sel == `MCIF_SEL_GRP1))
      next_grp1 = ACC_WDATA[1:0];                                            // R11 R12
    fall_s  = grp1[`MCIF_GRP1_S_BIT] && !next_grp1[`MCIF_GRP1_S_BIT];
    fall_ns = grp1[`MCIF_GRP1_NS_BIT] && !next_grp1[`MCIF_GRP1_NS_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update

  always @(posedge REF_CLK) begin
    if (RST) begin
      ctrl      <= `MCIF_CTRL_RESET;
      grp1      <= `MCIF_GRP1_RESET;                                         // R15
      {sre_en, irq_bypass_disable, dfb, sysreg_interface_enable} <= `MCIF_SRE_RESET;                            // R22
      ACC_DONE  <= 1'b0;
      ACC_RESP  <= `MCIF_RESP_OK;
      ACC_RDATA <= 32'h0;
    end else begin
      ACC_DONE  <= ACC_VALID;
      ACC_RESP  <= ACC_VALID ? next_resp : `MCIF_RESP_OK;
      ACC_RDATA <= (ACC_VALID && !ACC_WRITE) ? next_rdata : 32'h0;
      grp1      <= next_grp1;
      if (do_write && (sel == `MCIF_SEL_CTRL))
        ctrl <= ACC_WDATA[2:0];                                              // R24
      if (do_write && (sel == `MCIF_SEL_SRE)) begin
        sre_en <= ACC_WDATA[`MCIF_SRE_EN_BIT];
        if (IRQ_BYPASS_SUPPORTED != 0)
          irq_bypass_disable <= ACC_WDATA[`MCIF_SRE_DIB_BIT];                               // R18
        if (FIQ_BYPASS_SUPPORTED != 0)
          dfb <= ACC_WDATA[`MCIF_SRE_DFB_BIT];                               // R19
        if (SYSREG_ONLY == 0)
          sysreg_interface_enable <= ACC_WDATA[`MCIF_SRE_SRE_BIT];                               // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the interface logic, all registered

  always @(posedge REF_CLK) begin
    if (RST) begin
      EOI_SPLIT_MODE_MONITOR        <= 1'b0;
      SHARED_BINARY_POINT_NONSECURE <= 1'b0;
      SHARED_BINARY_POINT_SECURE    <= 1'b0;
      SECURE_GROUP1_GATE            <= 1'b0;
      NONSECURE_GROUP1_GATE         <= 1'b0;
      IRQ_BYPASS_DISABLE            <= 1'b0;
      FIQ_BYPASS_DISABLE            <= 1'b0;
      SYSREG_INTERFACE_ENABLE       <= 1'b0;
      LOWER_SRE_TRAP_EL3            <= 1'b0;
      OTHER_SYSREG_UNDEF            <= 1'b0;
      PRIORITY_DROP                 <= 1'b0;
      DEACTIVATE                    <= 1'b0;
      BPR1_USES_BPR0                <= 1'b0;
      HPPI_RETARGET                 <= 1'b0;
      HPPI_RELEASE                  <= 1'b0;
    end else begin
      EOI_SPLIT_MODE_MONITOR        <= ctrl[`MCIF_CTRL_EOI_BIT];
      SHARED_BINARY_POINT_NONSECURE <= ctrl[`MCIF_CTRL_CBPNS_BIT];
      SHARED_BINARY_POINT_SECURE    <= ctrl[`MCIF_CTRL_CBPS_BIT];
      SECURE_GROUP1_GATE            <= grp1[`MCIF_GRP1_S_BIT];               // R11
      NONSECURE_GROUP1_GATE         <= grp1[`MCIF_GRP1_NS_BIT];              // R12
      IRQ_BYPASS_DISABLE            <= dib_eff;                              // R18
      FIQ_BYPASS_DISABLE            <= dfb_eff;                              // R19
      SYSREG_INTERFACE_ENABLE       <= sre_eff;
      // Lower-level trap is skipped when the sysreg interface is off
      LOWER_SRE_TRAP_EL3            <= LOWER_SRE_ACCESS && !sre_en_eff &&
                                       !(NONSECURE && (EXC_LEVEL == 2'h1) && HYP_TRAP_CP15_C12); // R16
      OTHER_SYSREG_UNDEF            <= OTHER_SYSREG_ACCESS && !sre_eff;      // R20
      PRIORITY_DROP                 <= EOI_WRITE && EOI_AT_EL3;              // R1 R2
      // In combined mode a deactivate register write has no defined effect; it is dropped
      DEACTIVATE                    <= EOI_AT_EL3 &&
                                       ((EOI_WRITE && !ctrl[`MCIF_CTRL_EOI_BIT]) ||   // R1
                                        (DEACT_WRITE && ctrl[`MCIF_CTRL_EOI_BIT]));   // R2
      BPR1_USES_BPR0                <= BPR1_ACCESS &&
                                       (NONSECURE ? ctrl[`MCIF_CTRL_CBPNS_BIT] :       // R3 R4
                                        (!MONITOR_MODE && ctrl[`MCIF_CTRL_CBPS_BIT])); // R5
      HPPI_RETARGET                 <= HPPI_VALID && HPPI_GROUP1 && HPPI_ONE_OF_N &&
                                       (HPPI_SECURE ? fall_s : fall_ns);     // R13
      HPPI_RELEASE                  <= HPPI_VALID && HPPI_GROUP1 &&
                                       (HPPI_SECURE ? fall_s : fall_ns);     // R14
    end
  end

endmodule // mcif_regs

// *** sim/mcif_regs_monitor.sv ***
// Purpose: Port assertions for the monitor register bank
// Assumes: Core model keeps coprocessor fields fixed
// Notes:   Bound to every mcif_regs instance
`timescale 1ns/1ps
module mcif_chk (
  input wire        REF_CLK,
  input wire        RST,
  input wire        ACC_VALID,
  input wire        ACC_WRITE,
  input wire [2:0]  ACC_OPC2,
  input wire [31:0] ACC_WDATA,
  input wire        MONITOR_MODE,
  input wire        EOI_WRITE,
  input wire        EOI_AT_EL3,
  input wire        LOWER_SRE_ACCESS,
  input wire        ACC_DONE,
  input wire [1:0]  ACC_RESP,
  input wire        EOI_SPLIT_MODE_MONITOR,
  input wire        SECURE_GROUP1_GATE,
  input wire        NONSECURE_GROUP1_GATE,
  input wire        SYSREG_INTERFACE_ENABLE,
  input wire        LOWER_SRE_TRAP_EL3,
  input wire        PRIORITY_DROP,
  input wire        DEACTIVATE,
  input wire        HPPI_RELEASE
);
  reg [1:0] wd;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Helper delays write data so the gate check needs no local variable
  always @(posedge REF_CLK) wd <= ACC_WDATA[1:0];
  ////////////////////////////////////////////////////////////
  answer_next_a: assert property (ACC_VALID |=> ACC_DONE)
    else $error("access not answered");
  eoi_combined_a: assert property (EOI_WRITE && EOI_AT_EL3 && !EOI_SPLIT_MODE_MONITOR |=> PRIORITY_DROP && DEACTIVATE)
    else $error("combined eoi wrong");
  eoi_split_a: assert property (EOI_WRITE && EOI_AT_EL3 && EOI_SPLIT_MODE_MONITOR |=> PRIORITY_DROP && !DEACTIVATE)
    else $error("split eoi wrong");
  monitor_only_a: assert property (ACC_VALID && !MONITOR_MODE |=> ACC_DONE && ACC_RESP != 2'h0)
    else $error("non monitor access accepted");
  gate_write_a: assert property (ACC_VALID && ACC_WRITE && ACC_OPC2 == 3'h7 && MONITOR_MODE
    && SYSREG_INTERFACE_ENABLE |-> ##2 {SECURE_GROUP1_GATE, NONSECURE_GROUP1_GATE} == $past(wd))
    else $error("group1 gates not written");
  sre_off_undef_a: assert property (ACC_VALID && ACC_OPC2 == 3'h4 && MONITOR_MODE
    && !SYSREG_INTERFACE_ENABLE |=> ACC_RESP == 2'h1)
    else $error("control access not undefined");
  gate_reset_a: assert property ($fell(RST) |-> !SECURE_GROUP1_GATE && !NONSECURE_GROUP1_GATE)
    else $error("gates not cleared by reset");
  lower_no_trap_a: assert property (LOWER_SRE_ACCESS && !SYSREG_INTERFACE_ENABLE |=> !LOWER_SRE_TRAP_EL3)
    else $error("lower access trapped");
  cover property (HPPI_RELEASE);
  cover property (ACC_DONE && ACC_RESP == 2'h2);
  cover property (DEACTIVATE && !PRIORITY_DROP);
endmodule // mcif_chk

bind mcif_regs mcif_chk u_chk (.*);

// *** sim/mcif_core.sv ***
// Purpose: Core model issuing coprocessor register accesses
// Assumes: Bank answers one cycle after the strobe
// Notes:   Only the opc2 field is varied
`timescale 1ns/1ps
`include "mcif_defines.vh"
module mcif_core (
  input  wire        ck,
  input  wire        done,
  input  wire [1:0]  resp,
  input  wire [31:0] rd,
  output reg         vld,
  output reg         wr,
  output reg  [2:0]  op2,
  output reg  [31:0] wd,
  output wire [3:0]  cp,
  output wire [2:0]  op1,
  output wire [3:0]  crn,
  output wire [3:0]  crm
);
  assign cp = `MCIF_COPROC;
  assign op1 = `MCIF_OPC1;
  assign crn = `MCIF_CRN;
  assign crm = `MCIF_CRM;
  initial begin
    vld = 1'b0;
    wr = 1'b0;
    op2 = 3'h0;
    wd = 32'h0;
  end
  ////////////////////////////////////////////////////////////
  task acc(input w, input [2:0] o, input [31:0] d, output ok, output [1:0] r, output [31:0] q);
    begin
      @(posedge ck);
      #1;
      vld = 1'b1;
      wr = w;
      op2 = o;
      wd = d;
      @(posedge ck);
      #1;
      vld = 1'b0;
      // Released data is inverted so a stale value cannot pass
      wd = ~d;
      ok = done;
      r = resp;
      q = rd;
    end
  endtask
endmodule // mcif_core

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the monitor register bank
// Assumes: Default build with both bypasses supported
// Notes:   Pulse inputs share one vector
`timescale 1ns/1ps
module testbench;
  reg REF_CLK = 1'b0, RST = 1'b1, MONITOR_MODE = 1'b1, NONSECURE = 1'b0;
  reg HYP_TRAP_CP15_C12 = 1'b0, EOI_AT_EL3 = 1'b1, BANK_G1_SECURE = 1'b0, BANK_G1_DATA = 1'b0;
  reg HPPI_VALID = 1'b0, HPPI_GROUP1 = 1'b0, HPPI_SECURE = 1'b0, HPPI_ONE_OF_N = 1'b0;
  reg [1:0] EXC_LEVEL = 2'h3;
  reg [5:0] pv = 6'h00;
  integer miscompares = 0, n_tests = 0;
  wire ACC_VALID, ACC_WRITE, ACC_DONE;
  wire [3:0] ACC_COPROC, ACC_CRN, ACC_CRM;
  wire [2:0] ACC_OPC1, ACC_OPC2;
  wire [1:0] ACC_RESP;
  wire [31:0] ACC_WDATA, ACC_RDATA;
  wire EOI_SPLIT_MODE_MONITOR, SHARED_BINARY_POINT_NONSECURE, SHARED_BINARY_POINT_SECURE, SECURE_GROUP1_GATE;
  wire NONSECURE_GROUP1_GATE, IRQ_BYPASS_DISABLE, FIQ_BYPASS_DISABLE, SYSREG_INTERFACE_ENABLE;
  wire LOWER_SRE_TRAP_EL3, OTHER_SYSREG_UNDEF, PRIORITY_DROP, DEACTIVATE, BPR1_USES_BPR0, HPPI_RETARGET, HPPI_RELEASE;
  wire LOWER_SRE_ACCESS = pv[0], OTHER_SYSREG_ACCESS = pv[1], EOI_WRITE = pv[2];
  wire DEACT_WRITE = pv[3], BPR1_ACCESS = pv[4], BANK_G1_WRITE = pv[5];
  wire [6:0] po = {LOWER_SRE_TRAP_EL3, OTHER_SYSREG_UNDEF, PRIORITY_DROP, DEACTIVATE, BPR1_USES_BPR0,
                   HPPI_RETARGET, HPPI_RELEASE};
  wire [7:0] lv = {EOI_SPLIT_MODE_MONITOR, SHARED_BINARY_POINT_NONSECURE, SHARED_BINARY_POINT_SECURE,
                   SECURE_GROUP1_GATE, NONSECURE_GROUP1_GATE, IRQ_BYPASS_DISABLE, FIQ_BYPASS_DISABLE,
                   SYSREG_INTERFACE_ENABLE};
  mcif_regs uut (.*);
  mcif_core u_core (.ck(REF_CLK), .done(ACC_DONE), .resp(ACC_RESP), .rd(ACC_RDATA), .vld(ACC_VALID),
                    .wr(ACC_WRITE), .op2(ACC_OPC2), .wd(ACC_WDATA), .cp(ACC_COPROC), .op1(ACC_OPC1),
                    .crn(ACC_CRN), .crm(ACC_CRM));
  ////////////////////////////////////////////////////////////
  task end_sim;
    begin
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rw(input w, input [2:0] o, input [31:0] d, input [1:0] er, input [31:0] eq);
    reg ok;
    reg [1:0] r;
    reg [31:0] q;
    begin
      u_core.acc(w, o, d, ok, r, q);
      chk("done", 32'h1, {31'h0, ok});
      chk("resp", {30'h0, er}, {30'h0, r});
      chk("rdata", eq, q);
    end
  endtask
  task pls(input integer i, input [6:0] e);
    begin
      @(posedge REF_CLK);
      #1 pv[i] = 1'b1;
      @(posedge REF_CLK);
      #1 pv[i] = 1'b0;
      chk("pulses", {25'h0, e}, {25'h0, po});
    end
  endtask
  task md(input m, input n, input [1:0] e);
    begin
      MONITOR_MODE = m;
      NONSECURE = n;
      EXC_LEVEL = e;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
    begin
      chk("levels", 32'h0, {24'h0, lv});
      rw(0, 3'h5, 32'h0, 2'h0, 32'h0);
      rw(0, 3'h4, 32'h0, 2'h1, 32'h0);
      pls(0, 7'h00);
      pls(1, 7'h20);
    end
  endtask
  task t_sre;
    begin
      rw(1, 3'h5, 32'hFFFFFFFF, 2'h0, 32'h0);
      rw(0, 3'h5, 32'h0, 2'h0, 32'hF);
      chk("levels", 32'h7, {29'h0, lv[2:0]});
      rw(1, 3'h5, 32'h7, 2'h0, 32'h0);
      pls(0, 7'h40);
      pls(1, 7'h00);
      rw(1, 3'h5, 32'hF, 2'h0, 32'h0);
      pls(0, 7'h00);
    end
  endtask
  task t_ctrl;
    begin
      rw(1, 3'h4, 32'hFFFFFFFF, 2'h0, 32'h0);
      rw(0, 3'h4, 32'h0, 2'h0, 32'h7);
      chk("ctrl", 32'h7, {29'h0, lv[7:5]});
      md(0, 1, 2'h1);
      pls(4, 7'h04);
      md(0, 0, 2'h1);
      pls(4, 7'h04);
      md(1, 0, 2'h3);
      rw(1, 3'h4, 32'h4, 2'h0, 32'h0);
      md(0, 1, 2'h1);
      pls(4, 7'h00);
      md(0, 0, 2'h1);
      pls(4, 7'h00);
      md(1, 0, 2'h3);
      pls(2, 7'h10);
      pls(3, 7'h08);
      rw(1, 3'h4, 32'h0, 2'h0, 32'h0);
      pls(2, 7'h18);
      pls(3, 7'h00);
    end
  endtask
  task t_grp1;
    begin
      rw(1, 3'h7, 32'h3, 2'h0, 32'h0);
      rw(0, 3'h7, 32'h0, 2'h0, 32'h3);
      chk("gates", 32'h3, {30'h0, lv[4:3]});
      {HPPI_VALID, HPPI_GROUP1, HPPI_SECURE, HPPI_ONE_OF_N} = 4'hF;
      rw(1, 3'h7, 32'h1, 2'h0, 32'h0);
      chk("pulses", 32'h3, {25'h0, po});
      rw(1, 3'h7, 32'h3, 2'h0, 32'h0);
      {HPPI_VALID, HPPI_GROUP1, HPPI_SECURE, HPPI_ONE_OF_N} = 4'hE;
      rw(1, 3'h7, 32'h1, 2'h0, 32'h0);
      chk("pulses", 32'h1, {25'h0, po});
      {HPPI_VALID, HPPI_GROUP1, HPPI_SECURE, HPPI_ONE_OF_N} = 4'h0;
      BANK_G1_SECURE = 1'b1;
      BANK_G1_DATA = 1'b1;
      pls(5, 7'h00);
      rw(0, 3'h7, 32'h0, 2'h0, 32'h3);
      BANK_G1_SECURE = 1'b0;
      BANK_G1_DATA = 1'b0;
      pls(5, 7'h00);
      rw(0, 3'h7, 32'h0, 2'h0, 32'h2);
    end
  endtask
  task t_refuse;
    begin
      md(0, 0, 2'h3);
      rw(1, 3'h7, 32'h0, 2'h1, 32'h0);
      md(0, 1, 2'h1);
      HYP_TRAP_CP15_C12 = 1'b1;
      rw(1, 3'h7, 32'h0, 2'h2, 32'h0);
      HYP_TRAP_CP15_C12 = 1'b0;
      md(1, 0, 2'h3);
      rw(0, 3'h7, 32'h0, 2'h0, 32'h2);
      rw(0, 3'h0, 32'h0, 2'h1, 32'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial forever #4 REF_CLK = ~REF_CLK;
  // Whole run is under a hundred cycles, so this bound only trips on a hang
  initial begin
    #20000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge REF_CLK);
    #1 RST = 1'b0;
    t_reset;
    t_sre;
    t_ctrl;
    t_grp1;
    t_refuse;
    end_sim;
  end
endmodule // testbench
